// ===== hw/adcc_defs.vh
// register map, field positions, reset values and timing counts
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADCC_OFF_CTRL0 3'h0
`define ADCC_OFF_CTRL1 3'h1
`define ADCC_OFF_TRIG 3'h2
`define ADCC_OFF_RESH 3'h3
`define ADCC_OFF_RESL 3'h4
`define ADCC_OFF_STAT 3'h5
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ADCC_C0_EN 0
`define ADCC_C0_GO 1
`define ADCC_C0_CH_LO 2
`define ADCC_C0_CH_HI 6
`define ADCC_C1_FMT 7
`define ADCC_C1_CS_LO 4
`define ADCC_C1_CS_HI 6
`define ADCC_C1_REF_LO 0
`define ADCC_C1_REF_HI 1
`define ADCC_TR_LO 4
`define ADCC_TR_HI 7
`define ADCC_ST_FLAG 0
`define ADCC_ST_IE 1
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ADCC_RST_CTRL0 8'h00
`define ADCC_RST_CTRL1 8'h00
`define ADCC_RST_TRIG 4'h0
`define ADCC_RST_RES 8'h00
// ---------------------------------------------------------------
// trigger codes
// ---------------------------------------------------------------
`define ADCC_TRG_PWM1 4'h1
`define ADCC_TRG_PWM2 4'h2
`define ADCC_TRG_TMR0 4'h3
`define ADCC_TRG_TMR1 4'h4
`define ADCC_TRG_TMR2 4'h5
`define ADCC_TRG_CMP 4'h6
`define ADCC_TRG_PWM3 4'h7
`define ADCC_TRG_OF1 4'h8
`define ADCC_TRG_OF2 4'h9
`define ADCC_TRG_OF3 4'hA
// ---------------------------------------------------------------
// timing: conversion is 23 half bit periods (11.5 periods)
// ---------------------------------------------------------------
`define ADCC_HALF_TOTAL 5'h17
`define ADCC_HALF_FIRST 5'h03
`endif

// ===== hw/adcc_ctrl.v
// conversion control for a 10-bit successive-approximation converter
//
// Contract
// - enable powers core; go bit starts conversion
// - completion clears go, sets flag, loads results
// - go cleared mid-conversion stores filled partial result
// - reset clears registers, stops any conversion
// - sleep conversion only with RC clock; wakes
// - sleep, RC, irq off: power down after
// - sleep with other clock aborts, powers down
// - trigger rising edge sets go bit
// - four-bit trigger select decode
// - any enabled pwm irq condition triggers
// - timer wraps used as triggers set flags
// - five-bit channel select decode
// - go bit reads busy state
// - enable cleared means converter off
// - format bit selects right or left justify
// - three-bit conversion clock decode
// - two-bit positive reference decode
// - conversion lasts 11.5 bit periods
// - done flag set on every completion
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "adcc_defs.vh"
module adcc_ctrl (
  // clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // register port
  input wire [2:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  // system
  input wire SLEEP_I,
  input wire RC_CLK_I,
  output wire IRQ_O,
  output wire WAKE_O,
  // trigger sources
  input wire [11:0] PWM_MATCH_I,
  input wire [11:0] PWM_IE_I,
  input wire [2:0] PWM_OFFSET_HIT_I,
  input wire TIMER0_WRAP_I,
  input wire TIMER1_WRAP_I,
  input wire TIMER2_PERIOD_HIT_I,
  input wire COMPARATOR_OUT_SYNCED_I,
  output wire TIMER0_FLAG_SET_O,
  output wire TIMER1_FLAG_SET_O,
  // analog core
  input wire COMP_I,
  output wire POWER_O,
  output wire SAMPLE_O,
  output reg [9:0] TRIAL_O,
  output wire [3:0] PIN_SEL_O,
  output wire TEMP_SEL_O,
  output wire DAC_SEL_O,
  output wire FIXED_REF_SEL_O,
  output wire REF_SUPPLY_O,
  output wire REF_PIN_O,
  output wire REF_FIXED_O
);

// ---------------------------------------------------------------
// registers
// ---------------------------------------------------------------
localparam ST_IDLE = 2'b01;
localparam ST_CONV = 2'b10;
localparam [7:0] RST_C0 = `ADCC_RST_CTRL0;

reg [1:0] state;
reg converter_enable;
reg go;
reg [4:0] channel_select_field;
reg result_format;
reg [2:0] conversion_clock_field;
reg [1:0] positive_reference_field;
reg [3:0] trigger_source_field;
reg [7:0] result_high;
reg [7:0] result_low;
reg conversion_done_flag;
reg conversion_irq_enable;
reg sleep_off;
reg [4:0] half_cnt;
reg [5:0] div_cnt;
reg [9:0] sar;
reg [3:0] bit_idx;
reg any_bit;
reg trig_prev;
reg rc_s1;
reg rc_s2;
reg rc_s3;
reg rc_lvl;

wire wr_c0 = WR_I && (ADDR_I == `ADCC_OFF_CTRL0);
wire wr_c1 = WR_I && (ADDR_I == `ADCC_OFF_CTRL1);
wire wr_tr = WR_I && (ADDR_I == `ADCC_OFF_TRIG);
wire wr_rh = WR_I && (ADDR_I == `ADCC_OFF_RESH);
wire wr_rl = WR_I && (ADDR_I == `ADCC_OFF_RESL);
wire wr_st = WR_I && (ADDR_I == `ADCC_OFF_STAT);

// ---------------------------------------------------------------
// trigger selection
// ---------------------------------------------------------------
wire [2:0] pwm_irq;
genvar g;
generate
  for (g = 0; g < 3; g = g + 1) begin : g_pwm
    assign pwm_irq[g] =
      |(PWM_MATCH_I[4*g+3:4*g] & PWM_IE_I[4*g+3:4*g]);
  end
endgenerate

reg trig_lvl;
always @* begin
  case (trigger_source_field)
    `ADCC_TRG_PWM1: trig_lvl = pwm_irq[0];
    `ADCC_TRG_PWM2: trig_lvl = pwm_irq[1];
    `ADCC_TRG_TMR0: trig_lvl = TIMER0_WRAP_I;
    `ADCC_TRG_TMR1: trig_lvl = TIMER1_WRAP_I;
    `ADCC_TRG_TMR2: trig_lvl = TIMER2_PERIOD_HIT_I;
    `ADCC_TRG_CMP: trig_lvl = COMPARATOR_OUT_SYNCED_I;
    `ADCC_TRG_PWM3: trig_lvl = pwm_irq[2];
    `ADCC_TRG_OF1: trig_lvl = PWM_OFFSET_HIT_I[0];
    `ADCC_TRG_OF2: trig_lvl = PWM_OFFSET_HIT_I[1];
    `ADCC_TRG_OF3: trig_lvl = PWM_OFFSET_HIT_I[2];
    default: trig_lvl = 1'b0;
  endcase
end

wire trig_edge = trig_lvl && !trig_prev;
assign TIMER0_FLAG_SET_O = trig_edge &&
  (trigger_source_field == `ADCC_TRG_TMR0);
assign TIMER1_FLAG_SET_O = trig_edge &&
  (trigger_source_field == `ADCC_TRG_TMR1);

// ---------------------------------------------------------------
// conversion clock: half bit period ticks
// ---------------------------------------------------------------
wire use_rc = (conversion_clock_field[1:0] == 2'b11);
reg [5:0] half_div;
always @* begin
  case (conversion_clock_field)
    3'h0: half_div = 6'h01;
    3'h4: half_div = 6'h02;
    3'h1: half_div = 6'h04;
    3'h5: half_div = 6'h08;
    3'h2: half_div = 6'h10;
    3'h6: half_div = 6'h20;
    default: half_div = 6'h01;
  endcase
end

wire rc_edge = (rc_s2 == rc_s3) && (rc_s3 != rc_lvl);
wire half_tick = use_rc ? rc_edge : (div_cnt == half_div - 6'h01);

always @(posedge CLK_I or negedge RST_N_I) begin
  if (!RST_N_I) begin
    rc_s1 <= 1'b0;
    rc_s2 <= 1'b0;
    rc_s3 <= 1'b0;
    rc_lvl <= 1'b0;
  end else begin
    rc_s1 <= RC_CLK_I;
    rc_s2 <= rc_s1;
    rc_s3 <= rc_s2;
    if (rc_edge) begin
      rc_lvl <= rc_s3;
    end
  end
end

// ---------------------------------------------------------------
// conversion control
// ---------------------------------------------------------------
wire busy = (state == ST_CONV);
wire sleep_abort = SLEEP_I && !use_rc;
wire sw_abort = wr_c0 && !WDATA_I[`ADCC_C0_GO] && busy;
wire finish = busy && half_tick &&
  (half_cnt == `ADCC_HALF_TOTAL - 5'h01);
wire decide = busy && half_tick && half_cnt[0] &&
  (half_cnt >= `ADCC_HALF_FIRST) && !finish;
wire en_next = wr_c0 ? WDATA_I[`ADCC_C0_EN] : converter_enable;
wire start = !busy && en_next && !sleep_abort && !sleep_off &&
  ((wr_c0 && WDATA_I[`ADCC_C0_GO]) || trig_edge);

// partial result: undecided bits copy the last decided bit
reg [9:0] fill;
integer i;
always @* begin
  fill = sar;
  for (i = 0; i < 10; i = i + 1) begin
    if ((i <= bit_idx) && (half_cnt < `ADCC_HALF_TOTAL - 5'h01)) begin
      fill[i] = any_bit ? sar[bit_idx + 4'h1] : 1'b0;
    end
  end
end

wire [9:0] next_sar = COMP_I ? (sar | (10'h001 << bit_idx)) : sar;
wire [9:0] load_val = finish ? sar : fill;
wire load = finish || (sw_abort && !sleep_abort);

always @(posedge CLK_I or negedge RST_N_I) begin
  if (!RST_N_I) begin
    state <= ST_IDLE;
    converter_enable <= RST_C0[`ADCC_C0_EN];
    go <= 1'b0;
    channel_select_field <= 5'h00;
    result_format <= 1'b0;
    conversion_clock_field <= 3'h0;
    positive_reference_field <= 2'h0;
    trigger_source_field <= `ADCC_RST_TRIG;
    result_high <= `ADCC_RST_RES;
    result_low <= `ADCC_RST_RES;
    conversion_done_flag <= 1'b0;
    conversion_irq_enable <= 1'b0;
    sleep_off <= 1'b0;
    half_cnt <= 5'h00;
    div_cnt <= 6'h00;
    sar <= 10'h000;
    bit_idx <= 4'h9;
    any_bit <= 1'b0;
    trig_prev <= 1'b0;
    TRIAL_O <= 10'h000;
  end else begin
    trig_prev <= trig_lvl;
    if (wr_c0) begin
      converter_enable <= WDATA_I[`ADCC_C0_EN];
      channel_select_field <=
        WDATA_I[`ADCC_C0_CH_HI:`ADCC_C0_CH_LO];
    end
    if (wr_c1) begin
      result_format <= WDATA_I[`ADCC_C1_FMT];
      conversion_clock_field <= WDATA_I[`ADCC_C1_CS_HI:`ADCC_C1_CS_LO];
      positive_reference_field <=
        WDATA_I[`ADCC_C1_REF_HI:`ADCC_C1_REF_LO];
    end
    if (wr_tr) begin
      trigger_source_field <= WDATA_I[`ADCC_TR_HI:`ADCC_TR_LO];
    end
    if (wr_st) begin
      conversion_irq_enable <= WDATA_I[`ADCC_ST_IE];
    end
    // flag: software clears by writing 0, completion wins
    if (finish) begin
      conversion_done_flag <= 1'b1;
    end else if (wr_st && !WDATA_I[`ADCC_ST_FLAG]) begin
      conversion_done_flag <= 1'b0;
    end
    // sleep power-down, released on wake
    if (!SLEEP_I) begin
      sleep_off <= 1'b0;
    end else if (sleep_abort ||
                 (finish && !conversion_irq_enable)) begin
      sleep_off <= 1'b1;
    end
    // result registers: hardware load wins over software write
    if (load) begin
      if (result_format) begin
        result_high <= {6'h00, load_val[9:8]};
        result_low <= load_val[7:0];
      end else begin
        result_high <= load_val[9:2];
        result_low <= {load_val[1:0], 6'h00};
      end
    end else begin
      if (wr_rh) begin
        result_high <= WDATA_I;
      end
      if (wr_rl) begin
        result_low <= WDATA_I;
      end
    end
    // half-period divider
    if (!busy || half_tick) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
    case (state)
      ST_IDLE: begin
        if (start) begin
          state <= ST_CONV;
          go <= 1'b1;
          half_cnt <= 5'h00;
          sar <= 10'h000;
          bit_idx <= 4'h9;
          any_bit <= 1'b0;
          TRIAL_O <= 10'h200;
        end
      end
      ST_CONV: begin
        if (!en_next || sleep_abort || sw_abort || finish) begin
          state <= ST_IDLE;
          go <= 1'b0;
          TRIAL_O <= 10'h000;
        end else if (half_tick) begin
          half_cnt <= half_cnt + 5'h01;
          if (decide) begin
            sar <= next_sar;
            any_bit <= 1'b1;
            if (bit_idx != 4'h0) begin
              bit_idx <= bit_idx - 4'h1;
              TRIAL_O <= next_sar | (10'h001 << (bit_idx - 4'h1));
            end else begin
              TRIAL_O <= next_sar;
            end
          end
        end
      end
      default: begin
        state <= ST_IDLE;
        go <= 1'b0;
      end
    endcase
  end
end

// ---------------------------------------------------------------
// read port: data valid the cycle after the strobe only
// ---------------------------------------------------------------
always @(posedge CLK_I or negedge RST_N_I) begin
  if (!RST_N_I) begin
    RDATA_O <= 8'h00;
  end else if (RD_I) begin
    case (ADDR_I)
      `ADCC_OFF_CTRL0:
        RDATA_O <= {1'b0, channel_select_field, go,
                    converter_enable};
      `ADCC_OFF_CTRL1:
        RDATA_O <= {result_format, conversion_clock_field, 2'h0,
                    positive_reference_field};
      `ADCC_OFF_TRIG: RDATA_O <= {trigger_source_field, 4'h0};
      `ADCC_OFF_RESH: RDATA_O <= result_high;
      `ADCC_OFF_RESL: RDATA_O <= result_low;
      `ADCC_OFF_STAT:
        RDATA_O <= {6'h00, conversion_irq_enable,
                    conversion_done_flag};
      default: RDATA_O <= 8'h00;
    endcase
  end else begin
    RDATA_O <= 8'h00;
  end
end

// ---------------------------------------------------------------
// analog side controls
// ---------------------------------------------------------------
assign IRQ_O = conversion_done_flag && conversion_irq_enable;
assign WAKE_O = SLEEP_I && IRQ_O;
assign POWER_O = converter_enable && !sleep_off;
assign SAMPLE_O = POWER_O && !busy;

generate
  for (g = 0; g < 4; g = g + 1) begin : g_pin
    assign PIN_SEL_O[g] = (channel_select_field == g);
  end
endgenerate
assign TEMP_SEL_O = (channel_select_field == 5'h1D);
assign DAC_SEL_O = (channel_select_field == 5'h1E);
assign FIXED_REF_SEL_O = (channel_select_field == 5'h1F);

assign REF_SUPPLY_O = (positive_reference_field == 2'h0);
assign REF_PIN_O = (positive_reference_field == 2'h2);
assign REF_FIXED_O = (positive_reference_field == 2'h3);

endmodule // adcc_ctrl

// ===== test/adcc_sar_model.sv
// behavioural analog core: comparator against a fixed input level
`timescale 1ns/1ps
module adcc_sar_model (
  // clock
  input wire clk_i,
  // core side
  input wire power_i,
  input wire [9:0] trial_i,
  input wire [9:0] level_i,
  output reg comp_o
);
  initial comp_o = 1'h0;
  // an unpowered core gives no usable decision, so it toggles
  always @(posedge clk_i) begin
    comp_o <= power_i ? (level_i >= trial_i) : ~comp_o;
  end
endmodule // adcc_sar_model

// ===== test/adcc_ctrl_checker.sv
// port assertions for the conversion control block
`timescale 1ns/1ps
module adcc_ctrl_checker (
  // clock and reset
  input wire CLK_I,
  input wire RST_N_I,
  // bus and system
  input wire [2:0] ADDR_I,
  input wire WR_I,
  input wire SLEEP_I,
  input wire IRQ_O,
  input wire WAKE_O,
  // triggers
  input wire TIMER0_WRAP_I,
  input wire TIMER1_WRAP_I,
  input wire TIMER0_FLAG_SET_O,
  input wire TIMER1_FLAG_SET_O,
  // analog core
  input wire POWER_O,
  input wire SAMPLE_O,
  input wire [9:0] TRIAL_O,
  input wire [3:0] PIN_SEL_O,
  input wire TEMP_SEL_O,
  input wire DAC_SEL_O,
  input wire FIXED_REF_SEL_O,
  input wire REF_SUPPLY_O,
  input wire REF_PIN_O,
  input wire REF_FIXED_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ---------------------------------------------------------------
  // conversion steps
  // ---------------------------------------------------------------
  sequence conv_start;
    $rose(TRIAL_O != 10'h000);
  endsequence
  sequence first_trial;
    (TRIAL_O == 10'h200) [*3];
  endsequence
  trial_start_a: assert property (conv_start |-> first_trial)
    else $error("first trial code wrong");
  busy_sample_a: assert property (TRIAL_O != 10'h000 |-> !SAMPLE_O)
    else $error("sampling while converting");
  sample_power_a: assert property (SAMPLE_O |-> POWER_O)
    else $error("sampling while unpowered");
  // ---------------------------------------------------------------
  // flags and selects
  // ---------------------------------------------------------------
  wake_level_a: assert property (WAKE_O == (SLEEP_I && IRQ_O))
    else $error("wake level wrong");
  irq_clear_a: assert property ($fell(IRQ_O) |->
    $past(WR_I) && $past(ADDR_I) == 3'h5)
    else $error("irq dropped without status write");
  chan_onehot_a: assert property ($onehot0({PIN_SEL_O, TEMP_SEL_O,
    DAC_SEL_O, FIXED_REF_SEL_O}))
    else $error("several channels selected");
  ref_onehot_a: assert property ($onehot0({REF_SUPPLY_O,
    REF_PIN_O, REF_FIXED_O}))
    else $error("several references selected");
  t0_flag_a: assert property (TIMER0_FLAG_SET_O |->
    $rose(TIMER0_WRAP_I))
    else $error("timer0 flag without wrap edge");
  t1_flag_a: assert property (TIMER1_FLAG_SET_O |->
    $rose(TIMER1_WRAP_I))
    else $error("timer1 flag without wrap edge");
endmodule // adcc_ctrl_checker
bind adcc_ctrl adcc_ctrl_checker u_adcc_ctrl_checker (.CLK_I, .RST_N_I,
  .ADDR_I, .WR_I, .SLEEP_I, .IRQ_O, .WAKE_O, .TIMER0_WRAP_I, .TIMER1_WRAP_I,
  .TIMER0_FLAG_SET_O, .TIMER1_FLAG_SET_O, .POWER_O, .SAMPLE_O, .TRIAL_O,
  .PIN_SEL_O, .TEMP_SEL_O, .DAC_SEL_O, .FIXED_REF_SEL_O, .REF_SUPPLY_O,
  .REF_PIN_O, .REF_FIXED_O);

// ===== test/adcc_ctrl_bench.sv
// self-checking bench for the conversion control block
`timescale 1ns/1ps
module adcc_ctrl_bench;
  typedef struct packed {
    logic [2:0] cs;
    logic fmt;
    logic [4:0] ch;
    logic [1:0] rf;
    logic [9:0] lv;
    logic [15:0] cnt;
    logic [6:0] sel;
    logic [2:0] rs;
  } adcc_row_t;
  adcc_row_t rows [6];
  reg clk, rst_n, wr, rd, slp, rc, rc_run;
  reg [2:0] addr;
  reg [7:0] wdata, d, eh, el;
  reg [9:0] src, level, m;
  reg [11:0] ie;
  reg [1:0] f;
  wire [7:0] rdata;
  wire [9:0] trial;
  wire [3:0] pin;
  wire irq, wake, t0f, t1f, comp, pwr, smp, tmp, dac, fxd, rsup, rpin, rfix;
  int fail_count, samples_checked, n;
  always #5 clk = ~clk;
  always #37 if (rc_run) rc = ~rc;
  adcc_ctrl u_adcc_ctrl (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .SLEEP_I(slp),
    .RC_CLK_I(rc), .IRQ_O(irq), .WAKE_O(wake),
    .PWM_MATCH_I({src[6], 4'h0, src[1], 4'h0, src[0], 1'h0}),
    .PWM_IE_I(ie), .PWM_OFFSET_HIT_I(src[9:7]), .TIMER0_WRAP_I(src[2]),
    .TIMER1_WRAP_I(src[3]), .TIMER2_PERIOD_HIT_I(src[4]),
    .COMPARATOR_OUT_SYNCED_I(src[5]), .TIMER0_FLAG_SET_O(t0f),
    .TIMER1_FLAG_SET_O(t1f), .COMP_I(comp), .POWER_O(pwr), .SAMPLE_O(smp),
    .TRIAL_O(trial), .PIN_SEL_O(pin), .TEMP_SEL_O(tmp), .DAC_SEL_O(dac),
    .FIXED_REF_SEL_O(fxd), .REF_SUPPLY_O(rsup), .REF_PIN_O(rpin),
    .REF_FIXED_O(rfix));
  adcc_sar_model u_adcc_sar_model (.clk_i(clk), .power_i(pwr),
    .trial_i(trial), .level_i(level), .comp_o(comp));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task tmo(input int k, input int lim);
    if (k >= lim) begin
      fail_count++;
      final_report;
    end
  endtask
  task wreg(input [2:0] a, input [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task rreg(input [2:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task wdone;
    n = 0;
    d = 8'h02;
    while (d[1] && n < 200) begin
      rreg(3'h0);
      n++;
    end
    tmo(n, 200);
  endtask
  task wait_sig(input bit want_wake);
    n = 0;
    while ((want_wake ? wake !== 1'h1 : pwr !== 1'h0) && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    tmo(n, 2000);
  endtask
  task pulse(input [9:0] v);
    @(posedge clk);
    src <= v;
    #1 f = {t1f, t0f};
    @(posedge clk);
    src <= 10'h000;
    repeat (2) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    {clk, rst_n, wr, rd, slp, rc, rc_run} = 7'h00;
    {addr, wdata, src, level, d, f} = 41'h0;
    ie = 12'h842;
    rows[0] = {3'h0, 1'h1, 5'h00, 2'h0, 10'h2A5, 16'h0016, 7'h01, 3'h4};
    rows[1] = {3'h4, 1'h0, 5'h01, 2'h2, 10'h15A, 16'h002D, 7'h02, 3'h2};
    rows[2] = {3'h1, 1'h1, 5'h02, 2'h3, 10'h3FF, 16'h005B, 7'h04, 3'h1};
    rows[3] = {3'h5, 1'h0, 5'h03, 2'h1, 10'h000, 16'h00B7, 7'h08, 3'h0};
    rows[4] = {3'h2, 1'h1, 5'h1D, 2'h0, 10'h001, 16'h016F, 7'h10, 3'h4};
    rows[5] = {3'h6, 1'h0, 5'h1E, 2'h0, 10'h200, 16'h02DF, 7'h20, 3'h4};
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      level <= rows[i].lv;
      eh = rows[i].fmt ? {6'h00, rows[i].lv[9:8]} : rows[i].lv[9:2];
      el = rows[i].fmt ? rows[i].lv[7:0] : {rows[i].lv[1:0], 6'h00};
      wreg(3'h1, {rows[i].fmt, rows[i].cs, 2'h0, rows[i].rf});
      wreg(3'h0, {1'h0, rows[i].ch, 2'h1});
      #1 chk({fxd, dac, tmp, pin}, rows[i].sel, "channel");
      chk({rsup, rpin, rfix}, rows[i].rs, "reference");
      repeat (4) @(posedge clk);
      wreg(3'h0, {1'h0, rows[i].ch, 2'h3});
      @(posedge clk);
      #1 n = 0;
      while (smp !== 1'h1 && n < 800) begin
        @(posedge clk);
        #1 n++;
      end
      tmo(n, 800);
      chk(n, rows[i].cnt, "duration");
      rreg(3'h0);
      chk(d[1], 1'h0, "busy");
      rreg(3'h5);
      chk(d[0], 1'h1, "flag");
      rreg(3'h3);
      chk(d, eh, "result high");
      rreg(3'h4);
      chk(d, el, "result low");
      wreg(3'h5, 8'h00);
    end
    // software abort after three decided bits
    wreg(3'h1, 8'h80);
    level <= 10'h380;
    wreg(3'h0, 8'h03);
    repeat (7) @(posedge clk);
    wreg(3'h0, 8'h01);
    rreg(3'h3);
    chk(d, 8'h03, "abort high");
    rreg(3'h4);
    chk(d, 8'hFF, "abort low");
    wreg(3'h1, 8'hFF);
    rreg(3'h1);
    chk(d, 8'hF3, "control 1");
    wreg(3'h2, 8'hFF);
    rreg(3'h2);
    chk(d, 8'hF0, "trigger reg");
    wreg(3'h0, 8'hFC);
    #1 chk({fxd, dac, tmp, pin}, 7'h40, "channel");
    chk(pwr, 1'h0, "disabled");
    rreg(3'h0);
    chk(d, 8'h7C, "control 0");
    wreg(3'h0, 8'h91);
    #1 chk({fxd, dac, tmp, pin}, 7'h00, "no channel");
    // sleep with a divided clock aborts
    wreg(3'h2, 8'h00);
    wreg(3'h1, 8'h60);
    wreg(3'h0, 8'h03);
    repeat (3) @(posedge clk);
    slp <= 1'h1;
    repeat (2) @(posedge clk);
    #1 chk(pwr, 1'h0, "sleep power");
    rreg(3'h0);
    chk(d, 8'h01, "sleep control");
    rreg(3'h3);
    chk(d, 8'h03, "sleep result");
    @(posedge clk);
    slp <= 1'h0;
    @(posedge clk);
    #1 chk(pwr, 1'h1, "awake power");
    // sleep with the rc clock, irq on then off
    rc_run = 1'h1;
    wreg(3'h5, 8'h02);
    wreg(3'h1, 8'h30);
    wreg(3'h0, 8'h03);
    slp <= 1'h1;
    wait_sig(1'b1);
    chk(irq, 1'h1, "irq");
    @(posedge clk);
    slp <= 1'h0;
    wreg(3'h5, 8'h02);
    #1 chk(irq, 1'h0, "irq cleared");
    wreg(3'h5, 8'h00);
    wreg(3'h1, 8'h70);
    wreg(3'h0, 8'h03);
    slp <= 1'h1;
    wait_sig(1'b0);
    rreg(3'h5);
    chk(d, 8'h01, "rc sleep flag");
    rreg(3'h0);
    chk(d, 8'h01, "rc sleep control");
    @(posedge clk);
    slp <= 1'h0;
    rc_run = 1'h0;
    wreg(3'h1, 8'h00);
    // every trigger code, wrong sources first
    for (int c = 0; c < 16; c++) begin
      wreg(3'h2, {c[3:0], 4'h0});
      m = (c >= 1 && c <= 10) ? 10'h001 << (c - 1) : 10'h000;
      pulse(~m);
      rreg(3'h0);
      chk(d[1], 1'h0, "other source");
      chk(f, 2'h0, "timer flag");
      if (m != 10'h000) begin
        pulse(m);
        chk(f, {c == 4, c == 3}, "timer flag");
        rreg(3'h0);
        chk(d[1], 1'h1, "trigger");
        wdone;
      end
    end
    @(posedge clk);
    ie <= 12'h000;
    wreg(3'h2, 8'h10);
    pulse(10'h001);
    rreg(3'h0);
    chk(d[1], 1'h0, "masked pwm");
    // unmapped place, then reset during a conversion
    wreg(3'h6, 8'hFF);
    rreg(3'h6);
    chk(d, 8'h00, "unmapped");
    wreg(3'h0, 8'h03);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    #1 chk({pwr, trial}, 11'h000, "reset core");
    for (int a = 0; a < 7; a++) begin
      rreg(a[2:0]);
      chk(d, 8'h00, "reset register");
    end
    final_report;
  end
endmodule // adcc_ctrl_bench
